// ### design/access_gate.sv
// priority check of the external access conditions
`timescale 1ns/10ps
`default_nettype none
module access_gate (
  input wire logic power_up,
  input wire logic debug_power,
  input wire logic double_lock,
  input wire logic os_lock,
  input wire logic allowed,
  output dbg_pmu_pkg::cond_t cond,
  output logic err,
  output logic sticky
);
  import dbg_pmu_pkg::*;
  // first true condition wins, scanned from the most severe
  always_comb begin
    if (!debug_power || !power_up) begin
      cond = COND_OFF;
    end else if (double_lock) begin
      cond = COND_DBL_LOCK;
    end else if (os_lock) begin
      cond = COND_OS_LOCK;
    end else if (!allowed) begin
      cond = COND_DISABLED;
    end else begin
      cond = COND_DEFAULT;
    end
    err = cond != COND_DEFAULT;
    sticky = cond == COND_DISABLED;
  end
endmodule
`default_nettype wire

// ### design/dbg_pmu_pkg.sv
// constants and types for the debug and monitor access gate
package dbg_pmu_pkg;
  localparam int NUM_CNT = 6;
  localparam int EV_W = 32;
  localparam int EV_IDX_W = 5;
  localparam int SYNC_PINS = 5;
  localparam int TAG_W = 8;

  localparam logic [7:0] OFF_LOCK = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_CNTEN = 8'h08;
  localparam logic [7:0] OFF_RESP = 8'h0C;
  localparam logic [7:0] OFF_ISTAT = 8'h10;
  localparam logic [7:0] OFF_IMASK = 8'h14;
  localparam logic [7:0] OFF_SWINC = 8'h18;
  localparam logic [7:0] OFF_EVSEL = 8'h20;
  localparam logic [7:0] OFF_EVCNT = 8'h40;
  localparam logic [7:0] OFF_CCLO = 8'h60;
  localparam logic [7:0] OFF_CCHI = 8'h64;
  localparam logic [7:0] OFF_MON_BASE = 8'h20;

  localparam int LOCK_OS_BIT = 0;
  localparam int LOCK_DBL_BIT = 1;
  localparam int STAT_PWR_UP = 0;
  localparam int STAT_DBL_LOCK = 1;
  localparam int STAT_DBG_DENY = 2;
  localparam int STAT_MON_DENY = 3;
  localparam int STAT_OS_LOCK = 4;
  localparam int ISTAT_DENY = 7;
  localparam int ISTAT_W = 8;
  localparam int RESP_SW_LSB = 0;
  localparam int RESP_HALT_LSB = 2;

  localparam logic OS_LOCK_RST = 1'b1;
  localparam logic DBL_LOCK_RST = 1'b0;
  localparam logic [3:0] RESP_RST = 4'h0;
  localparam logic [SYNC_PINS-1:0] PIN_RST = 5'h10;
  localparam int PIN_PWR_UP = 0;
  localparam int PIN_DPWR = 1;
  localparam int PIN_DBG_OK = 2;
  localparam int PIN_MON_OK = 3;
  localparam int PIN_WARM_N = 4;

  localparam logic [7:0] EV_SWINC = 8'h00;
  localparam logic [7:0] EV_RSVD = 8'h0F;
  localparam logic [7:0] EV_CYCLES = 8'h11;
  localparam logic [7:0] EV_LIMIT = 8'h20;

  typedef enum logic [2:0] {
    COND_OFF,
    COND_DBL_LOCK,
    COND_OS_LOCK,
    COND_DISABLED,
    COND_DEFAULT
  } cond_t;

  typedef enum logic [1:0] {
    RESP_IGNORE,
    RESP_EXCEPTION,
    RESP_HALT,
    RESP_UNUSED
  } resp_t;
endpackage

// ### design/debug_pmu_access_gate.sv
// debug and monitor register block with gated external port
//
// Chosen here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module debug_pmu_access_gate (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  input wire logic power_up_status_bit,
  input wire logic debug_power,
  input wire logic ext_debug_allow,
  input wire logic ext_monitor_allow,
  input wire logic warm_reset_n,
  input wire logic [dbg_pmu_pkg::EV_W-1:0] event_in,
  input wire logic sw_debug_event,
  input wire logic halt_debug_event,
  input wire logic wp_hit,
  input wire logic [dbg_pmu_pkg::TAG_W-1:0] wp_tag,
  output logic debug_exception,
  output logic debug_halt,
  output logic wp_sync,
  output logic [dbg_pmu_pkg::TAG_W-1:0] wp_tag_out,
  output logic irq
);
  import dbg_pmu_pkg::*;

  // pin synchronisers: a change is taken once stages two and three agree
  logic [SYNC_PINS-1:0] pins, s1_q, s2_q, s3_q, filt_q;
  assign pins = {warm_reset_n, ext_monitor_allow, ext_debug_allow, debug_power,
                 power_up_status_bit};
  for (genvar b = 0; b < SYNC_PINS; b++) begin : g_sync
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        s1_q[b] <= PIN_RST[b];
        s2_q[b] <= PIN_RST[b];
        s3_q[b] <= PIN_RST[b];
        filt_q[b] <= PIN_RST[b];
      end else begin
        s1_q[b] <= pins[b];
        s2_q[b] <= s1_q[b];
        s3_q[b] <= s2_q[b];
        filt_q[b] <= (s2_q[b] == s3_q[b]) ? s3_q[b] : filt_q[b];
      end
    end
  end

  logic pwr_up, dpwr, warm;
  assign pwr_up = filt_q[PIN_PWR_UP];
  assign dpwr = filt_q[PIN_DPWR];
  assign warm = !filt_q[PIN_WARM_N];

  // register state
  logic os_lock_q, os_lock_d, dbl_lock_q, dbl_lock_d;
  logic dbg_deny_q, dbg_deny_d, mon_deny_q, mon_deny_d;
  logic [NUM_CNT:0] cnten_q, cnten_d;
  logic [3:0] resp_q, resp_d;
  logic [ISTAT_W-1:0] istat_q, istat_d, imask_q, imask_d;
  logic [7:0] evsel_q [NUM_CNT];
  logic [7:0] evsel_d [NUM_CNT];
  logic [31:0] cnt_q [NUM_CNT];
  logic [63:0] cc_q, cc_wd;
  logic [NUM_CNT-1:0] cnt_wr, cnt_ovf, swinc;
  logic [31:0] cnt_wd [NUM_CNT];
  logic cc_wr, cc_ovf;

  // bus state
  logic aw_q, aw_d, ar_q, ar_d, hready_q, hready_d;
  logic [7:0] aaddr_q, aaddr_d;
  logic [31:0] hrdata_q, hrdata_d, prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q;

  function automatic logic [31:0] rd_val(input logic [7:0] a);
    logic [31:0] v;
    v = '0;
    case (a)
      OFF_LOCK: begin
        v[LOCK_OS_BIT] = os_lock_q;
        v[LOCK_DBL_BIT] = dbl_lock_q;
      end
      OFF_STAT: begin
        v[STAT_PWR_UP] = pwr_up;
        v[STAT_DBL_LOCK] = dbl_lock_q;
        v[STAT_DBG_DENY] = dbg_deny_q;
        v[STAT_MON_DENY] = mon_deny_q;
        v[STAT_OS_LOCK] = os_lock_q;
      end
      OFF_CNTEN: v[NUM_CNT:0] = cnten_q;
      OFF_RESP: v[3:0] = resp_q;
      OFF_ISTAT: v[ISTAT_W-1:0] = istat_q;
      OFF_IMASK: v[ISTAT_W-1:0] = imask_q;
      OFF_CCLO: v = cc_q[31:0];
      OFF_CCHI: v = cc_q[63:32];
      default: v = '0;
    endcase
    for (int i = 0; i < NUM_CNT; i++) begin
      if (a == OFF_EVSEL + 8'(4 * i)) v = {24'h0, evsel_q[i]};
      if (a == OFF_EVCNT + 8'(4 * i)) v = cnt_q[i];
    end
    return v;
  endfunction

  // external port: decision taken in the setup phase, answered in the access phase
  logic eval, is_mon, ext_ro, gate_err, gate_sticky;
  cond_t cond;
  assign eval = psel && !penable;
  assign is_mon = paddr >= OFF_MON_BASE;
  assign ext_ro = (paddr == OFF_STAT) || (paddr >= OFF_EVCNT && paddr <= OFF_CCHI);

  access_gate u_gate (
    .power_up(pwr_up),
    .debug_power(dpwr),
    .double_lock(dbl_lock_q),
    .os_lock(os_lock_q),
    .allowed(is_mon ? filt_q[PIN_MON_OK] : filt_q[PIN_DBG_OK]),
    .cond(cond),
    .err(gate_err),
    .sticky(gate_sticky)
  );

  // two write ports: external first, internal second so it wins a shared register
  logic [1:0] we;
  logic [7:0] wa [2];
  logic [31:0] wd [2];
  always_comb begin
    we[0] = eval && pwrite && !gate_err && !ext_ro;
    wa[0] = paddr;
    wd[0] = pwdata;
    we[1] = aw_q && hready_q;
    wa[1] = aaddr_q;
    wd[1] = hwdata;
  end

  always_comb begin
    os_lock_d = os_lock_q;
    dbl_lock_d = dbl_lock_q;
    dbg_deny_d = dbg_deny_q;
    mon_deny_d = mon_deny_q;
    cnten_d = cnten_q;
    resp_d = resp_q;
    istat_d = istat_q;
    imask_d = imask_q;
    evsel_d = evsel_q;
    cnt_wr = '0;
    cnt_wd = cnt_q;
    cc_wr = 1'b0;
    cc_wd = cc_q;
    swinc = '0;
    for (int p = 0; p < 2; p++) begin
      if (we[p]) begin
        case (wa[p])
          OFF_LOCK: begin
            os_lock_d = wd[p][LOCK_OS_BIT];
            dbl_lock_d = wd[p][LOCK_DBL_BIT];
          end
          OFF_STAT: begin
            if (wd[p][STAT_DBG_DENY]) dbg_deny_d = 1'b0;
            if (wd[p][STAT_MON_DENY]) mon_deny_d = 1'b0;
          end
          OFF_CNTEN: cnten_d = wd[p][NUM_CNT:0];
          OFF_RESP: resp_d = wd[p][3:0];
          OFF_ISTAT: istat_d = istat_d & ~wd[p][ISTAT_W-1:0];
          OFF_IMASK: imask_d = wd[p][ISTAT_W-1:0];
          OFF_SWINC: swinc = wd[p][NUM_CNT-1:0];
          OFF_CCLO: begin
            cc_wr = 1'b1;
            cc_wd[31:0] = wd[p];
          end
          OFF_CCHI: begin
            cc_wr = 1'b1;
            cc_wd[63:32] = wd[p];
          end
          default: ;
        endcase
        for (int i = 0; i < NUM_CNT; i++) begin
          if (wa[p] == OFF_EVSEL + 8'(4 * i)) evsel_d[i] = wd[p][7:0];
          if (wa[p] == OFF_EVCNT + 8'(4 * i)) begin
            cnt_wr[i] = 1'b1;
            cnt_wd[i] = wd[p];
          end
        end
      end
    end
    if (warm) begin
      cnten_d = '0;
      istat_d[NUM_CNT:0] = '0;
    end
    // hardware sets land after software clears so no event is lost
    if (eval && gate_sticky && !is_mon) dbg_deny_d = 1'b1;
    if (eval && gate_sticky && is_mon) mon_deny_d = 1'b1;
    istat_d[NUM_CNT:0] = istat_d[NUM_CNT:0] | {cc_ovf, cnt_ovf};
    if (eval && gate_sticky) istat_d[ISTAT_DENY] = 1'b1;
  end

  always_comb begin
    aw_d = aw_q;
    ar_d = 1'b0;
    aaddr_d = aaddr_q;
    hready_d = 1'b1;
    hrdata_d = hrdata_q;
    if (hready_q) aw_d = 1'b0;
    if (hsel && htrans[1] && hready) begin
      aaddr_d = (haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hFF;
      aw_d = hwrite;
      ar_d = !hwrite;
      // reads wait one cycle so a write just before is already visible
      hready_d = hwrite;
    end
    if (ar_q) hrdata_d = rd_val(aaddr_q);
    pready_d = eval;
    pslverr_d = eval && gate_err;
    prdata_d = (eval && !pwrite && !gate_err) ? rd_val(paddr) : 32'h0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      os_lock_q <= OS_LOCK_RST;
      dbl_lock_q <= DBL_LOCK_RST;
      dbg_deny_q <= 1'b0;
      mon_deny_q <= 1'b0;
      cnten_q <= '0;
      resp_q <= RESP_RST;
      istat_q <= '0;
      imask_q <= '0;
      for (int i = 0; i < NUM_CNT; i++) evsel_q[i] <= '0;
      aw_q <= 1'b0;
      ar_q <= 1'b0;
      aaddr_q <= '0;
      hready_q <= 1'b1;
      hrdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      irq_q <= 1'b0;
    end else begin
      os_lock_q <= os_lock_d;
      dbl_lock_q <= dbl_lock_d;
      dbg_deny_q <= dbg_deny_d;
      mon_deny_q <= mon_deny_d;
      cnten_q <= cnten_d;
      resp_q <= resp_d;
      istat_q <= istat_d;
      imask_q <= imask_d;
      evsel_q <= evsel_d;
      aw_q <= aw_d;
      ar_q <= ar_d;
      aaddr_q <= aaddr_d;
      hready_q <= hready_d;
      hrdata_q <= hrdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      irq_q <= |(istat_q & imask_q);
    end
  end

  // event counters; reserved selections count nothing
  for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
    logic rsvd, inc;
    assign rsvd = (evsel_q[i] == EV_RSVD) || (evsel_q[i] >= EV_LIMIT);
    assign inc = !rsvd && ((evsel_q[i] == EV_CYCLES) ||
                 ((evsel_q[i] == EV_SWINC) ? swinc[i] : event_in[evsel_q[i][EV_IDX_W-1:0]]));
    pmu_counter #(.W(32)) u_cnt (
      .clk(hclk),
      .rst_n(hresetn),
      .clr(warm),
      .en(cnten_q[i]),
      .inc(inc),
      .wr(cnt_wr[i]),
      .wdata(cnt_wd[i]),
      .count_q(cnt_q[i]),
      .ovf(cnt_ovf[i])
    );
  end

  pmu_counter #(.W(64)) u_cycles (
    .clk(hclk),
    .rst_n(hresetn),
    .clr(warm),
    .en(cnten_q[NUM_CNT]),
    .inc(1'b1),
    .wr(cc_wr),
    .wdata(cc_wd),
    .count_q(cc_q),
    .ovf(cc_ovf)
  );

  // debug event response; os lock holds software and halting events off, watchpoints still pass
  resp_t act, sw_resp, halt_resp;
  logic exc_q, halt_q, wps_q;
  logic [TAG_W-1:0] wtag_q;
  always_comb begin
    sw_resp = resp_t'(resp_q[RESP_SW_LSB +: 2]);
    halt_resp = resp_t'(resp_q[RESP_HALT_LSB +: 2]);
    act = RESP_IGNORE;
    if (halt_debug_event) begin
      act = halt_resp;
    end else if (sw_debug_event) begin
      act = sw_resp;
    end
    if (os_lock_q) act = RESP_IGNORE;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exc_q <= 1'b0;
      halt_q <= 1'b0;
      wps_q <= 1'b0;
      wtag_q <= '0;
    end else begin
      exc_q <= act == RESP_EXCEPTION;
      halt_q <= act == RESP_HALT;
      wps_q <= wp_hit;
      wtag_q <= wp_tag;
    end
  end

  assign hreadyout = hready_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;
  assign debug_exception = exc_q;
  assign debug_halt = halt_q;
  assign wp_sync = wps_q;
  assign wp_tag_out = wtag_q;
  assign irq = irq_q;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_off_error: assert property (eval && !pwr_up |=> pslverr_q && pready_q)
    else $error("access while powered off not refused");
  a_nopwr_zero: assert property (eval && !dpwr |=> pslverr_q && prdata_q == 32'h0)
    else $error("access without debug power not refused with zero data");
  a_dbl_lock_error: assert property (eval && pwr_up && dpwr && dbl_lock_q
    |=> pslverr_q)
    else $error("double lock did not refuse access");
  a_os_lock_error: assert property (eval && pwr_up && dpwr && !dbl_lock_q && os_lock_q
    |=> pslverr_q)
    else $error("os lock did not refuse access");
  a_dbg_deny_set: assert property (eval && !is_mon && cond == COND_DISABLED
    |=> dbg_deny_q)
    else $error("debug denial flag not set");
  a_mon_deny_cause: assert property ($rose(mon_deny_q)
    |-> $past(eval && is_mon && gate_sticky))
    else $error("monitor denial flag set without its cause");
  a_default_ok: assert property (eval && cond == COND_DEFAULT |=> pready_q && !pslverr_q)
    else $error("default access answered with error");
  a_halt_resp: assert property (halt_debug_event && !os_lock_q && halt_resp == RESP_HALT
    |=> halt_q && !exc_q)
    else $error("halting event did not enter debug state alone");
  a_wp_sync: assert property (wp_hit |=> wps_q && wtag_q == $past(wp_tag))
    else $error("watchpoint not reported with its instruction");
endmodule
`default_nettype wire

// ### design/pmu_counter.sv
// one monitor counter with write, enable and overflow
`timescale 1ns/10ps
`default_nettype none
module pmu_counter #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic en,
  input wire logic inc,
  input wire logic wr,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] count_q,
  output logic ovf
);
  logic [W-1:0] count_d;

  always_comb begin
    count_d = count_q;
    ovf = 1'b0;
    if (clr) begin
      count_d = '0;
    end else if (wr) begin
      count_d = wdata;
    end else if (en && inc) begin
      count_d = count_q + {{(W-1){1'b0}}, 1'b1};
      ovf = &count_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end
endmodule
`default_nettype wire

// ### tb/apb_debugger.sv
// external debugger model driving the gated apb port
`timescale 1ns/10ps
`default_nettype none
module apb_debugger (
  input wire logic pclk,
  input wire logic pready,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // request held until pready is sampled; released address and data lines show the inverse
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ### tb/debug_pmu_access_gate_tb.sv
// self-checking bench for the debug and monitor access gate
`timescale 1ns/10ps
`default_nettype none
module debug_pmu_access_gate_tb;
  import dbg_pmu_pkg::*;
  typedef struct {logic [32:0] v; logic [32:0] m;} note_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, pready, pslverr, psel, penable, pwrite;
  logic [31:0] hrdata, prdata, pwdata, r;
  logic [7:0] paddr, wp_tag_out;
  logic pwr_up = 1'b1, dpwr = 1'b1, dbg_ok = 1'b1, mon_ok = 1'b1, warm_n = 1'b1;
  logic [31:0] event_in = 32'h0;
  logic sw_ev = 1'b0, halt_ev = 1'b0, wp_hit = 1'b0;
  logic [7:0] wp_tag = 8'h00;
  logic dbg_exc, dbg_halt, wp_sync, irq;
  logic rd_ph = 1'b0, ev_ph = 1'b0;
  int err_count = 0;
  int checks = 0;
  int n = 0;
  note_t q[$];

  always #10 hclk = ~hclk;

  debug_pmu_access_gate i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .power_up_status_bit(pwr_up),
    .debug_power(dpwr), .ext_debug_allow(dbg_ok), .ext_monitor_allow(mon_ok),
    .warm_reset_n(warm_n), .event_in(event_in), .sw_debug_event(sw_ev),
    .halt_debug_event(halt_ev), .wp_hit(wp_hit), .wp_tag(wp_tag),
    .debug_exception(dbg_exc), .debug_halt(dbg_halt), .wp_sync(wp_sync),
    .wp_tag_out(wp_tag_out), .irq(irq)
  );

  apb_debugger i_dbg (
    .pclk(hclk), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata)
  );

  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic pop(input string nm, input logic [32:0] s);
    note_t e;
    if (q.size() == 0) begin
      err_count++;
      $display("mismatch %s expected none seen %h", nm, s);
    end else begin
      e = q.pop_front();
      chk(nm, s & e.m, e.v);
    end
  endtask

  // results are picked up where they appear, oldest note first
  always @(posedge hclk) begin
    if (rd_ph && hreadyout) pop("hrdata", {hresp, hrdata});
    if (pready) pop("apb", {pslverr, prdata});
    if (ev_ph) pop("event", {22'h0, dbg_exc, dbg_halt, wp_sync, wp_tag_out});
    if (hreadyout) rd_ph = hsel && htrans[1] && !hwrite;
    ev_ph = sw_ev | halt_ev | wp_hit;
  end

  task automatic note(input logic [32:0] v, input logic [32:0] m = 33'h1FFFFFFFF);
    q.push_back('{v, m});
  endtask

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, {24'h0, a}, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    note({1'b0, e});
    ahb(1'b0, {24'h0, a}, 32'h0);
  endtask

  task automatic ap(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [32:0] e);
    note(e);
    i_dbg.xfer(w, a, d);
  endtask

  // pins pass a synchroniser, so give them time to land
  task automatic pins(input logic [4:0] v);
    {warm_n, mon_ok, dbg_ok, dpwr, pwr_up} <= v;
    repeat (8) @(posedge hclk);
  endtask

  task automatic pulse(input logic [2:0] k, input logic [7:0] t);
    @(posedge hclk);
    {sw_ev, halt_ev, wp_hit} <= k;
    wp_tag <= t;
    @(posedge hclk);
    {sw_ev, halt_ev, wp_hit} <= 3'h0;
    @(posedge hclk);
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    stop_test();
  end

  initial begin
    r = $urandom(32'hF4198BCE);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
    rd(OFF_LOCK, 32'h1);
    rd(OFF_STAT, 32'h11);
    note(33'h0);
    ahb(1'b0, 32'h100, 32'h0);
    pins(5'h13);
    ap(1'b0, 8'h00, 32'h0, 33'h100000000);
    wr(OFF_LOCK, 32'h2);
    ap(1'b0, 8'h00, 32'h0, 33'h100000000);
    rd(OFF_STAT, 32'h03);
    pins(5'h12);
    ap(1'b0, 8'h00, 32'h0, 33'h100000000);
    pins(5'h11);
    ap(1'b0, 8'h20, 32'h0, 33'h100000000);
    pins(5'h13);
    wr(OFF_LOCK, 32'h0);
    ap(1'b0, 8'h00, 32'h0, 33'h100000000);
    ap(1'b1, OFF_EVSEL, 32'h5, 33'h100000000);
    rd(OFF_STAT, 32'h0D);
    rd(OFF_EVSEL, 32'h0);
    rd(OFF_ISTAT, 32'h80);
    wr(OFF_IMASK, 32'h80);
    repeat (3) @(posedge hclk);
    chk("irq", {32'h0, irq}, 33'h1);
    wr(OFF_ISTAT, 32'h80);
    repeat (3) @(posedge hclk);
    chk("irq", {32'h0, irq}, 33'h0);
    wr(OFF_STAT, 32'h0C);
    rd(OFF_STAT, 32'h01);
    pins(5'h1F);
    ap(1'b1, 8'h24, 32'h3, 33'h0);
    rd(8'h24, 32'h3);
    wr(OFF_EVSEL, 32'h3);
    wr(8'h28, {24'h0, EV_RSVD});
    wr(8'h2C, 32'h3);
    wr(OFF_CNTEN, 32'h7);
    // random traffic on every event line, only event 3 is counted
    for (int i = 0; i < 20; i++) begin
      @(posedge hclk);
      r = $urandom;
      event_in <= r;
      n += r[3];
    end
    @(posedge hclk);
    event_in <= 32'h0;
    repeat (3) @(posedge hclk);
    wr(OFF_CNTEN, 32'h0);
    for (int i = 0; i < 2; i++) rd(8'(OFF_EVCNT + 4 * i), 32'(n));
    rd(8'h48, 32'h0);
    rd(8'h4C, 32'h0);
    ap(1'b1, OFF_EVCNT, 32'h0, 33'h0);
    ap(1'b0, OFF_EVCNT, 32'h0, {1'b0, 32'(n)});
    for (int c = 0; c < 4; c++) begin
      wr(OFF_RESP, 32'(c * 5));
      note({22'h0, c == 1, c == 2, 9'h0}, 33'h700);
      pulse(3'h4, 8'h00);
      note({22'h0, c == 1, c == 2, 9'h0}, 33'h700);
      pulse(3'h2, 8'h00);
    end
    wr(OFF_RESP, 32'h9);
    note(33'h200, 33'h700);
    pulse(3'h6, 8'h00);
    r = $urandom;
    note({22'h0, 3'h1, r[7:0]}, 33'h7FF);
    pulse(3'h1, r[7:0]);
    wr(OFF_LOCK, 32'h1);
    wr(OFF_RESP, 32'h5);
    note(33'h0, 33'h700);
    pulse(3'h4, 8'h00);
    wr(OFF_LOCK, 32'h0);
    wr(OFF_CCLO, 32'hFFFFFFFF);
    wr(OFF_CCHI, 32'h0);
    wr(OFF_CNTEN, 32'h40);
    repeat (5) @(posedge hclk);
    wr(OFF_CNTEN, 32'h0);
    rd(OFF_CCHI, 32'h1);
    // counter 5 counts cycles over two zero-wait writes, counter 4 one software step
    wr(8'h34, {24'h0, EV_CYCLES});
    wr(OFF_CNTEN, 32'h30);
    wr(OFF_SWINC, 32'h10);
    wr(OFF_CNTEN, 32'h0);
    rd(8'h50, 32'h1);
    rd(8'h54, 32'h6);
    pins(5'h0F);
    pins(5'h1F);
    rd(OFF_EVCNT, 32'h0);
    rd(OFF_EVSEL, 32'h3);
    rd(OFF_LOCK, 32'h0);
    repeat (4) @(posedge hclk);
    stop_test();
  end
endmodule
`default_nettype wire
